/* pkg/usart_aux_pkg.sv */
package usart_aux_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_RX_IDLE_TIMEOUT = 8'h24;
  localparam logic [7:0] OFF_TX_GUARD_TIME = 8'h28;
  localparam logic [7:0] OFF_SC_BAUD_RATIO = 8'h40;
  localparam logic [7:0] OFF_SC_ERROR_COUNT = 8'h44;
  localparam logic [7:0] OFF_IR_FILTER = 8'h4c;
  localparam logic [7:0] OFF_MANCHESTER = 8'h50;
  localparam logic [7:0] OFF_LIN_FRAME = 8'h54;

  // reset values
  localparam logic [16:0] RST_TIMEOUT = 17'h0_0000;
  localparam logic [7:0] RST_GUARD = 8'h00;
  localparam logic [10:0] RST_SC_DIVISOR = 11'h174;
  localparam logic [7:0] RST_ERROR_TALLY = 8'h00;
  localparam logic [7:0] RST_IR_FILTER = 8'h00;
  localparam logic [31:0] RST_MANCHESTER = 32'h3001_1004;
  localparam logic [31:0] RST_LIN_FRAME = 32'h0000_0000;
  localparam logic RST_IR_LINE = 1'b1; // infrared line idles high

  // writable bits and fixed-one bits of the coding setup, writable bits of the lin setup
  localparam logic [31:0] MAN_WRITE_MASK = 32'h530F_130F;
  localparam logic [31:0] MAN_FIXED_ONES = 32'h2000_0000;
  localparam logic [31:0] LIN_WRITE_MASK = 32'h0001_FFFF;

  // coding setup field positions
  localparam int MAN_TX_PREAMBLE_LEN_LSB = 0;
  localparam int MAN_TX_PREAMBLE_KIND_LSB = 8;
  localparam int MAN_TX_CODE_POLARITY = 12;
  localparam int MAN_RX_PREAMBLE_LEN_LSB = 16;
  localparam int MAN_RX_PREAMBLE_KIND_LSB = 24;
  localparam int MAN_RX_CODE_POLARITY = 28;
  localparam int MAN_DRIFT = 30;

  // lin frame setup field positions
  localparam int LIN_NODE_ACTION_LSB = 0;
  localparam int LIN_ID_PARITY_OFF = 2;
  localparam int LIN_CHECKSUM_OFF = 3;
  localparam int LIN_CHKTYP = 4;
  localparam int LIN_DLM = 5;
  localparam int LIN_FSDIS = 6;
  localparam int LIN_WKUPTYP = 7;
  localparam int LIN_DLC_LSB = 8;
  localparam int LIN_DMA_LOADS_CONFIG = 16;

  // node action codes
  localparam logic [1:0] ACT_PUBLISH = 2'h0;
  localparam logic [1:0] ACT_SUBSCRIBE = 2'h1;

  // preamble pattern codes (default polarity)
  typedef enum logic [1:0] {
    PRE_ALL_ONE = 2'h0,
    PRE_ALL_ZERO = 2'h1,
    PRE_ZERO_ONE = 2'h2,
    PRE_ONE_ZERO = 2'h3
  } preamble_kind_t;

  // coding settings handed to the serial core
  typedef struct packed {
    logic drift_recover;
    logic rx_code_polarity;
    preamble_kind_t rx_preamble_kind;
    logic [3:0] rx_preamble_len;
    logic rx_preamble_on;
    logic tx_code_polarity;
    preamble_kind_t tx_preamble_kind;
    logic [3:0] tx_preamble_len;
    logic tx_preamble_on;
  } man_cfg_t;

  // lin response settings handed to the serial core
  typedef struct packed {
    logic send_response;
    logic recv_response;
    logic checksum_on;
    logic classic_checksum;
    logic id_parity_on;
    logic frame_slot_off;
    logic wakeup_type;
    logic [8:0] response_bytes;
  } lin_cfg_t;

endpackage

/* rtl/usart_aux_mode_config.sv */
// The implementer's own choice: the APB register port.
`timescale 1ns/1ns
module usart_aux_mode_config #(
  parameter int TIMEOUT_BITS = 17,
  parameter int DIVISOR_BITS = 11
) (
  input wire logic ref_clk_i, // peripheral clock
  input wire logic resetn_i, // async reset, active low
  input wire logic psel_i, // apb select
  input wire logic penable_i, // apb access phase
  input wire logic pwrite_i, // apb direction
  input wire logic [7:0] paddr_i, // apb byte address
  input wire logic [31:0] pwdata_i, // apb write data
  output logic [31:0] prdata_o, // apb read data
  output logic pready_o, // apb ready
  output logic pslverr_o, // apb error on unmapped address
  input wire logic write_lock_i, // write protection on
  input wire logic bit_tick_i, // one pulse per bit period
  input wire logic rx_char_done_i, // received character, restarts time-out
  input wire logic tx_stop_done_i, // stop bit of a character sent
  input wire logic smartcard_mode_i, // smart-card mode selected
  input wire logic card_clk_tick_i, // one pulse per card clock period
  input wire logic sc_error_i, // smart-card transfer error pulse
  input wire logic oversample16_i, // receiver uses 16x oversampling
  input wire logic irda_rx_i, // infrared receive pin, async
  input wire logic dma_wr_i, // dma write to lin setup
  input wire logic [31:0] dma_wdata_i, // dma write data
  input wire logic [7:0] identifier_char_i, // current identifier character
  output logic rx_timeout_o, // time-out elapsed pulse
  output logic tx_guard_hold_o, // hold next start bit
  output logic sc_baud_tick_o, // smart-card baud pulse
  output logic irda_rx_filtered_o, // filtered infrared line
  output usart_aux_pkg::man_cfg_t man_cfg_o, // coding settings
  output usart_aux_pkg::lin_cfg_t lin_cfg_o // lin response settings
);

  // refuse counter widths that the registers cannot hold
  if (TIMEOUT_BITS < 1 || TIMEOUT_BITS > 17 || DIVISOR_BITS < 1 || DIVISOR_BITS > 11)
  begin
    $error("unsupported counter width");
  end

  typedef struct packed {
    // software visible registers
    logic [TIMEOUT_BITS-1:0] timeout_value;
    logic [7:0] guard_value;
    logic [DIVISOR_BITS-1:0] smartcard_divisor;
    logic [7:0] error_tally;
    logic [7:0] ir_filter;
    logic [31:0] manchester_setup;
    logic [31:0] lin_frame_setup;
    // counters and the infrared synchroniser
    logic to_running;
    logic [TIMEOUT_BITS-1:0] to_count;
    logic [7:0] guard_count;
    logic [DIVISOR_BITS-1:0] baud_count;
    logic ir_sync1;
    logic ir_sync2;
    logic [7:0] ir_count;
    // registered outputs
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic rx_timeout;
    logic tx_guard_hold;
    logic sc_baud_tick;
    logic irda_filtered;
    usart_aux_pkg::man_cfg_t man_cfg;
    usart_aux_pkg::lin_cfg_t lin_cfg;
  } state_t;

  // current and next copy of all state
  state_t st;
  state_t next_st;

  // response byte count from the length field or identifier bits
  function automatic logic [8:0] lin_len(input logic [31:0] setup, input logic [7:0] id);
    logic [8:0] len;
    len = 9'h000;
    if (!setup[usart_aux_pkg::LIN_DLM])
    begin
      len = {1'b0, setup[usart_aux_pkg::LIN_DLC_LSB +: 8]} + 9'h001;
    end
    else
    begin
      unique case (id[5:4])
        2'h0: len = 9'h002;
        2'h1: len = 9'h002;
        2'h2: len = 9'h004;
        default: len = 9'h008;
      endcase
    end
    return len;
  endfunction

  // bus decode and read path
  logic access;
  logic wr_en;
  logic rd_done;
  logic hit;
  logic [31:0] rd_mux;

  // apb phase decode; a write completes when ready is already high
  assign access = psel_i && penable_i;
  assign wr_en = access && st.pready && pwrite_i && !st.pslverr;
  // a read is taken at the wait-state edge, where its data is captured
  assign rd_done = access && !st.pready && !pwrite_i;

  // read mux and address decode
  always_comb
  begin
    hit = 1'b1;
    rd_mux = 32'h0000_0000;
    unique case (paddr_i)
      usart_aux_pkg::OFF_RX_IDLE_TIMEOUT: rd_mux[TIMEOUT_BITS-1:0] = st.timeout_value;
      usart_aux_pkg::OFF_TX_GUARD_TIME: rd_mux[7:0] = st.guard_value;
      usart_aux_pkg::OFF_SC_BAUD_RATIO: rd_mux[DIVISOR_BITS-1:0] = st.smartcard_divisor;
      usart_aux_pkg::OFF_SC_ERROR_COUNT: rd_mux[7:0] = st.error_tally;
      usart_aux_pkg::OFF_IR_FILTER: rd_mux[7:0] = st.ir_filter;
      usart_aux_pkg::OFF_MANCHESTER: rd_mux = st.manchester_setup;
      usart_aux_pkg::OFF_LIN_FRAME: rd_mux = st.lin_frame_setup;
      default: hit = 1'b0;
    endcase
  end

  // next state of registers, counters and outputs
  always_comb
  begin
    next_st = st;
    // bus answer and event pulses last one cycle
    next_st.pready = 1'b0;
    next_st.pslverr = 1'b0;
    next_st.rx_timeout = 1'b0;
    next_st.sc_baud_tick = 1'b0;

    // one wait state, then ready with data captured
    if (access && !st.pready)
    begin
      next_st.pready = 1'b1;
      next_st.pslverr = !hit;
      next_st.prdata = pwrite_i ? 32'h0000_0000 : rd_mux;
    end

    // software writes, protected ones only when unlocked
    if (wr_en && !write_lock_i)
    begin
      unique case (paddr_i)
        usart_aux_pkg::OFF_RX_IDLE_TIMEOUT:
          next_st.timeout_value = pwdata_i[TIMEOUT_BITS-1:0];
        usart_aux_pkg::OFF_TX_GUARD_TIME: next_st.guard_value = pwdata_i[7:0];
        usart_aux_pkg::OFF_SC_BAUD_RATIO:
          next_st.smartcard_divisor = pwdata_i[DIVISOR_BITS-1:0];
        usart_aux_pkg::OFF_IR_FILTER: next_st.ir_filter = pwdata_i[7:0];
        usart_aux_pkg::OFF_MANCHESTER:
          next_st.manchester_setup = (pwdata_i & usart_aux_pkg::MAN_WRITE_MASK)
            | usart_aux_pkg::MAN_FIXED_ONES;
        default:
        begin
        end
      endcase
    end
    // lin setup is unprotected; software wins over a dma write
    if (wr_en && paddr_i == usart_aux_pkg::OFF_LIN_FRAME)
    begin
      next_st.lin_frame_setup = pwdata_i & usart_aux_pkg::LIN_WRITE_MASK;
    end
    else if (dma_wr_i && st.lin_frame_setup[usart_aux_pkg::LIN_DMA_LOADS_CONFIG])
    begin
      next_st.lin_frame_setup = (dma_wdata_i & usart_aux_pkg::LIN_WRITE_MASK);
      // the dma cannot clear its own permission
      next_st.lin_frame_setup[usart_aux_pkg::LIN_DMA_LOADS_CONFIG] = 1'b1;
    end

    // error tally: read clears, a new error in that cycle still counts
    // clearing where the data is captured loses no error in between
    if (rd_done && paddr_i == usart_aux_pkg::OFF_SC_ERROR_COUNT)
    begin
      next_st.error_tally = {7'h00, sc_error_i};
    end
    else if (sc_error_i && st.error_tally != 8'hFF)
    begin
      next_st.error_tally = st.error_tally + 8'h01;
    end

    // receiver time-out in bit periods, restarted by each character
    if (st.timeout_value == '0)
    begin
      next_st.to_running = 1'b0;
      next_st.to_count = '0;
    end
    else if (rx_char_done_i)
    begin
      next_st.to_running = 1'b1;
      next_st.to_count = '0;
    end
    else if (st.to_running && bit_tick_i)
    begin
      // at or past the value, so lowering it mid-count cannot miss the end
      if (st.to_count + 1'b1 >= st.timeout_value)
      begin
        next_st.to_running = 1'b0;
        next_st.rx_timeout = 1'b1;
      end
      next_st.to_count = st.to_count + 1'b1;
    end

    // idle guard after each stop bit before the next start bit
    if (tx_stop_done_i && st.guard_value != 8'h00)
    begin
      next_st.tx_guard_hold = 1'b1;
      // a new stop bit restarts the count
      next_st.guard_count = 8'h00;
    end
    else if (st.tx_guard_hold && bit_tick_i)
    begin
      next_st.guard_count = st.guard_count + 8'h01;
      if (st.guard_count + 8'h01 >= st.guard_value)
      begin
        next_st.tx_guard_hold = 1'b0;
      end
    end

    // smart-card baud divider on the card clock
    if (!smartcard_mode_i || st.smartcard_divisor == '0)
    begin
      next_st.baud_count = '0;
    end
    else if (card_clk_tick_i)
    begin
      if (st.baud_count + 1'b1 >= st.smartcard_divisor)
      begin
        next_st.baud_count = '0;
        next_st.sc_baud_tick = 1'b1;
      end
      else
      begin
        next_st.baud_count = st.baud_count + 1'b1;
      end
    end

    // infrared line follows the input after it stays steady long enough
    next_st.ir_sync1 = irda_rx_i;
    next_st.ir_sync2 = st.ir_sync1;
    if (st.ir_sync2 == st.irda_filtered)
    begin
      next_st.ir_count = 8'h00;
    end
    else if (st.ir_count >= st.ir_filter)
    begin
      next_st.irda_filtered = st.ir_sync2;
      next_st.ir_count = 8'h00;
    end
    else
    begin
      next_st.ir_count = st.ir_count + 8'h01;
    end

    // coding settings decoded for the serial core
    next_st.man_cfg.drift_recover = st.manchester_setup[usart_aux_pkg::MAN_DRIFT]
      && oversample16_i;
    next_st.man_cfg.rx_code_polarity = st.manchester_setup[usart_aux_pkg::MAN_RX_CODE_POLARITY];
    next_st.man_cfg.tx_code_polarity = st.manchester_setup[usart_aux_pkg::MAN_TX_CODE_POLARITY];
    next_st.man_cfg.rx_preamble_kind = usart_aux_pkg::preamble_kind_t'(
      st.manchester_setup[usart_aux_pkg::MAN_RX_PREAMBLE_KIND_LSB +: 2]);
    next_st.man_cfg.tx_preamble_kind = usart_aux_pkg::preamble_kind_t'(
      st.manchester_setup[usart_aux_pkg::MAN_TX_PREAMBLE_KIND_LSB +: 2]);
    next_st.man_cfg.rx_preamble_len = st.manchester_setup[usart_aux_pkg::MAN_RX_PREAMBLE_LEN_LSB +: 4];
    next_st.man_cfg.rx_preamble_on =
      st.manchester_setup[usart_aux_pkg::MAN_RX_PREAMBLE_LEN_LSB +: 4] != 4'h0;
    next_st.man_cfg.tx_preamble_len = st.manchester_setup[usart_aux_pkg::MAN_TX_PREAMBLE_LEN_LSB +: 4];
    next_st.man_cfg.tx_preamble_on =
      st.manchester_setup[usart_aux_pkg::MAN_TX_PREAMBLE_LEN_LSB +: 4] != 4'h0;

    // lin response settings decoded for the serial core
    next_st.lin_cfg.send_response = st.lin_frame_setup[usart_aux_pkg::LIN_NODE_ACTION_LSB +: 2]
      == usart_aux_pkg::ACT_PUBLISH;
    next_st.lin_cfg.recv_response = st.lin_frame_setup[usart_aux_pkg::LIN_NODE_ACTION_LSB +: 2]
      == usart_aux_pkg::ACT_SUBSCRIBE;
    next_st.lin_cfg.checksum_on = !st.lin_frame_setup[usart_aux_pkg::LIN_CHECKSUM_OFF];
    next_st.lin_cfg.classic_checksum = st.lin_frame_setup[usart_aux_pkg::LIN_CHKTYP];
    next_st.lin_cfg.id_parity_on = !st.lin_frame_setup[usart_aux_pkg::LIN_ID_PARITY_OFF];
    next_st.lin_cfg.frame_slot_off = st.lin_frame_setup[usart_aux_pkg::LIN_FSDIS];
    next_st.lin_cfg.wakeup_type = st.lin_frame_setup[usart_aux_pkg::LIN_WKUPTYP];
    next_st.lin_cfg.response_bytes = lin_len(st.lin_frame_setup, identifier_char_i);
  end

  // state register
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      // registers take their reset values, the rest clears except the infrared path
      st <= '0;
      st.timeout_value <= usart_aux_pkg::RST_TIMEOUT[TIMEOUT_BITS-1:0];
      st.guard_value <= usart_aux_pkg::RST_GUARD;
      st.smartcard_divisor <= usart_aux_pkg::RST_SC_DIVISOR[DIVISOR_BITS-1:0];
      st.error_tally <= usart_aux_pkg::RST_ERROR_TALLY;
      st.ir_filter <= usart_aux_pkg::RST_IR_FILTER;
      st.manchester_setup <= usart_aux_pkg::RST_MANCHESTER;
      st.lin_frame_setup <= usart_aux_pkg::RST_LIN_FRAME;
      // infrared path starts at the idle line level, no false edge after reset
      st.ir_sync1 <= usart_aux_pkg::RST_IR_LINE;
      st.ir_sync2 <= usart_aux_pkg::RST_IR_LINE;
      st.irda_filtered <= usart_aux_pkg::RST_IR_LINE;
    end
    else
    begin
      st <= next_st;
    end
  end

  // outputs straight from the state register
  assign prdata_o = st.prdata;
  assign pready_o = st.pready;
  assign pslverr_o = st.pslverr;
  assign rx_timeout_o = st.rx_timeout;
  assign tx_guard_hold_o = st.tx_guard_hold;
  assign sc_baud_tick_o = st.sc_baud_tick;
  assign irda_rx_filtered_o = st.irda_filtered;
  assign man_cfg_o = st.man_cfg;
  assign lin_cfg_o = st.lin_cfg;

endmodule

/* verification/usart_aux_mode_config_props.sv */
`timescale 1ns/1ns
// port-level checks of the auxiliary mode block
module usart_aux_mode_config_props (
  input wire logic ref_clk_i, // clock
  input wire logic resetn_i, // reset, active low
  input wire logic psel_i, // select
  input wire logic penable_i, // access phase
  input wire logic pready_o, // ready
  input wire logic pslverr_o, // error
  input wire logic bit_tick_i, // bit tick
  input wire logic rx_timeout_o, // time-out pulse
  input wire logic tx_stop_done_i, // stop sent
  input wire logic tx_guard_hold_o, // guard running
  input wire logic smartcard_mode_i, // card mode
  input wire logic card_clk_tick_i, // card tick
  input wire logic sc_baud_tick_o, // baud pulse
  input wire logic oversample16_i, // 16x mode
  input wire usart_aux_pkg::man_cfg_t man_cfg_o, // coding
  input wire usart_aux_pkg::lin_cfg_t lin_cfg_o // lin
);
  default clocking @(posedge ref_clk_i);
  endclocking
  default disable iff (!resetn_i);
  // bus answer: one wait state, one-cycle ready
  chk_ready_wait: assert property ($rose(penable_i) && psel_i |-> !pready_o ##1 pready_o)
    else $error("ready not in second access cycle");
  chk_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("ready longer than one cycle");
  chk_err_ready: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  // event outputs follow their causes
  chk_timeout_tick: assert property (rx_timeout_o |-> $past(bit_tick_i))
    else $error("time-out not after a bit tick");
  chk_guard_start: assert property ($rose(tx_guard_hold_o)
    |-> $past(tx_stop_done_i))
    else $error("guard began without stop bit");
  chk_guard_end: assert property ($fell(tx_guard_hold_o) |-> $past(bit_tick_i))
    else $error("guard ended off a bit tick");
  chk_baud_cause: assert property (sc_baud_tick_o
    |-> $past(smartcard_mode_i) && $past(card_clk_tick_i))
    else $error("baud pulse without card tick");
  // decoded settings stay consistent
  chk_drift_gate: assert property (man_cfg_o.drift_recover |-> $past(oversample16_i))
    else $error("drift recovery without 16x");
  chk_preamble_on: assert property (
    man_cfg_o.tx_preamble_on == (man_cfg_o.tx_preamble_len != 0)
    && man_cfg_o.rx_preamble_on == (man_cfg_o.rx_preamble_len != 0))
    else $error("preamble enable wrong");
  chk_one_action: assert property (
    !(lin_cfg_o.send_response && lin_cfg_o.recv_response))
    else $error("send and receive together");
  cov_timeout: cover property (rx_timeout_o);
  cov_guard: cover property ($fell(tx_guard_hold_o));
  cov_baud: cover property (sc_baud_tick_o);
endmodule

/* verification/serial_far_end.sv */
`timescale 1ns/1ns
// far side: bit clock, card clock and infrared line
module serial_far_end #(
  parameter int BIT_DIV = 4,
  parameter int CARD_DIV = 2
) (
  input wire logic clk_i, // clock
  input wire logic resetn_i, // reset, active low
  input wire logic ir_low_i, // pull infrared line low
  output logic bit_tick_o, // bit period tick
  output logic card_tick_o, // card clock tick
  output logic irda_o // infrared line, idle high
);
  int cnt;
  // free-running period counter
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      cnt <= 0;
    else
      cnt <= cnt + 1;
  end
  // ticks are single-cycle pulses
  assign bit_tick_o = (cnt % BIT_DIV) == BIT_DIV - 1;
  assign card_tick_o = (cnt % CARD_DIV) == 1;
  assign irda_o = !ir_low_i;
endmodule

/* verification/usart_aux_mode_config_tb_top.sv */
`timescale 1ns/1ns
// self-checking bench for the auxiliary mode registers
module usart_aux_mode_config_tb_top;
  logic ref_clk_i = 0, resetn_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic write_lock_i = 0, rx_char_done_i = 0, tx_stop_done_i = 0, sc_error_i = 0;
  logic smartcard_mode_i = 0, oversample16_i = 0, dma_wr_i = 0, ir_low = 0;
  logic [7:0] paddr_i = 0, identifier_char_i = 0;
  logic [31:0] pwdata_i = 0, dma_wdata_i = 0, prdata_o, rd;
  logic pready_o, pslverr_o, bit_tick_i, card_clk_tick_i, irda_rx_i, err;
  logic rx_timeout_o, tx_guard_hold_o, sc_baud_tick_o, irda_rx_filtered_o;
  usart_aux_pkg::man_cfg_t man_cfg_o;
  usart_aux_pkg::lin_cfg_t lin_cfg_o;
  int miscompares = 0;
  int checked = 0;
  int n;
  initial forever #50 ref_clk_i = ~ref_clk_i;
  usart_aux_mode_config DUT (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .write_lock_i(write_lock_i), .bit_tick_i(bit_tick_i), .rx_char_done_i(rx_char_done_i),
    .tx_stop_done_i(tx_stop_done_i), .smartcard_mode_i(smartcard_mode_i),
    .card_clk_tick_i(card_clk_tick_i), .sc_error_i(sc_error_i),
    .oversample16_i(oversample16_i), .irda_rx_i(irda_rx_i), .dma_wr_i(dma_wr_i),
    .dma_wdata_i(dma_wdata_i), .identifier_char_i(identifier_char_i),
    .rx_timeout_o(rx_timeout_o), .tx_guard_hold_o(tx_guard_hold_o),
    .sc_baud_tick_o(sc_baud_tick_o), .irda_rx_filtered_o(irda_rx_filtered_o),
    .man_cfg_o(man_cfg_o), .lin_cfg_o(lin_cfg_o));
  serial_far_end far (.clk_i(ref_clk_i), .resetn_i(resetn_i), .ir_low_i(ir_low),
    .bit_tick_o(bit_tick_i), .card_tick_o(card_clk_tick_i), .irda_o(irda_rx_i));
  // compare and count
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one apb transfer, held until ready; only the watchdog ends the wait
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    psel_i <= 1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge ref_clk_i);
    penable_i <= 1;
    // ready and data settle mid-cycle and stand until the completing edge
    do @(negedge ref_clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    @(posedge ref_clk_i);
    psel_i <= 0;
    penable_i <= 0;
  endtask
  task rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(0, a, 0);
    chk(what, exp, rd);
  endtask
  // event pulse placed just after a bit tick
  task pulse(input int which);
    @(negedge ref_clk_i);
    while (bit_tick_i !== 1'b1) @(negedge ref_clk_i);
    @(posedge ref_clk_i);
    if (which == 0) rx_char_done_i <= 1;
    else tx_stop_done_i <= 1;
    @(posedge ref_clk_i);
    rx_char_done_i <= 0;
    tx_stop_done_i <= 0;
  endtask
  // bit ticks seen until time-out pulse or guard end
  task ticks(input int which);
    n = 0;
    repeat (100)
    begin
      @(negedge ref_clk_i);
      if (which == 0 ? rx_timeout_o === 1'b1 : tx_guard_hold_o !== 1'b1) break;
      n += bit_tick_i;
    end
  endtask
  task t_reset;
    rchk("timeout", 8'h24, 32'h0);
    rchk("guard", 8'h28, 32'h0);
    rchk("ratio", 8'h40, 32'h174);
    rchk("tally", 8'h44, 32'h0);
    rchk("filter", 8'h4c, 32'h0);
    rchk("coding", 8'h50, 32'h3001_1004);
    rchk("lin", 8'h54, 32'h0);
    apb(0, 8'h30, 0);
    chk("unmapped", 1, err);
    $display("reset values done");
  endtask
  task t_lock;
    write_lock_i <= 1;
    apb(1, 8'h28, 32'hff);
    apb(1, 8'h54, 32'ha0c);
    write_lock_i <= 0;
    rchk("locked guard", 8'h28, 32'h0);
    rchk("open lin", 8'h54, 32'ha0c);
    chk("lin cfg", 32'h800b, 32'(lin_cfg_o));
    apb(1, 8'h44, 32'h55);
    rchk("tally ro", 8'h44, 32'h0);
    $display("write lock done");
  endtask
  task t_timer;
    apb(1, 8'h24, 32'h1_ffff);
    rchk("max timeout", 8'h24, 32'h1_ffff);
    apb(1, 8'h24, 32'h3);
    pulse(0);
    ticks(0);
    chk("timeout ticks", 3, n);
    apb(1, 8'h24, 32'h0);
    pulse(0);
    ticks(0);
    chk("no timeout", 25, n);
    apb(1, 8'h28, 32'h2);
    pulse(1);
    ticks(1);
    chk("guard ticks", 2, n);
    apb(1, 8'h28, 32'h0);
    pulse(1);
    ticks(1);
    chk("no guard", 0, n);
    $display("timers done");
  endtask
  task t_card;
    apb(1, 8'h40, 32'h3);
    smartcard_mode_i <= 1;
    n = 0;
    repeat (20) @(negedge ref_clk_i) if (sc_baud_tick_o === 1'b1) break;
    repeat (20)
    begin
      @(negedge ref_clk_i);
      if (sc_baud_tick_o === 1'b1) break;
      n += card_clk_tick_i;
    end
    chk("card per baud", 3, n);
    apb(1, 8'h40, 32'h0);
    n = 0;
    repeat (2) @(posedge ref_clk_i);
    repeat (40) @(negedge ref_clk_i) n += sc_baud_tick_o;
    chk("baud off", 0, n);
    @(posedge ref_clk_i);
    sc_error_i <= 1;
    repeat (3) @(posedge ref_clk_i);
    sc_error_i <= 0;
    rchk("tally", 8'h44, 32'h3);
    rchk("tally clear", 8'h44, 32'h0);
    $display("smart card done");
  endtask
  task t_coding;
    oversample16_i <= 1;
    identifier_char_i <= 8'h20;
    apb(1, 8'h50, 32'h510f_0200);
    rchk("coding rb", 8'h50, 32'h710f_0200);
    chk("coding", {1'b1, 1'b1, 2'h1, 4'hf, 1'b1, 1'b0, 2'h2, 4'h0, 1'b0},
      32'(man_cfg_o));
    apb(1, 8'h54, 32'h21);
    rchk("lin rb", 8'h54, 32'h21);
    chk("lin id len", 32'h6804, 32'(lin_cfg_o));
    apb(1, 8'h54, 32'h22);
    rchk("lin rb2", 8'h54, 32'h22);
    chk("lin ignore", 32'h2804, 32'(lin_cfg_o));
    $display("coding done");
  endtask
  // dma write to the lin setup
  task dma(input logic [31:0] d, input logic [31:0] exp);
    dma_wr_i <= 1;
    dma_wdata_i <= d;
    @(posedge ref_clk_i);
    dma_wr_i <= 0;
    rchk("dma lin", 8'h54, exp);
  endtask
  task t_dma;
    dma(32'ha0c, 32'h22);
    apb(1, 8'h54, 32'h1_0000);
    dma(32'ha0c, 32'h1_0a0c);
    $display("dma done");
  endtask
  task t_ir;
    apb(1, 8'h4c, 32'h4);
    ir_low <= 1;
    repeat (3) @(posedge ref_clk_i);
    ir_low <= 0;
    n = 0;
    repeat (12) @(negedge ref_clk_i) n += (irda_rx_filtered_o !== 1'b1);
    chk("ir glitch", 0, n);
    @(posedge ref_clk_i);
    ir_low <= 1;
    repeat (12) @(posedge ref_clk_i);
    chk("ir low", 0, irda_rx_filtered_o);
    ir_low <= 0;
    $display("infrared done");
  endtask
  task test_done;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // main sequence
  initial
  begin
    repeat (5) @(posedge ref_clk_i);
    resetn_i <= 1;
    t_reset;
    t_lock;
    t_timer;
    t_card;
    t_coding;
    t_dma;
    t_ir;
    test_done;
  end
  // watchdog against hangs
  initial
  begin
    repeat (5000) @(posedge ref_clk_i);
    miscompares++;
    test_done;
  end
endmodule
bind usart_aux_mode_config usart_aux_mode_config_props props (.ref_clk_i(ref_clk_i),
  .resetn_i(resetn_i), .psel_i(psel_i), .penable_i(penable_i), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .bit_tick_i(bit_tick_i), .rx_timeout_o(rx_timeout_o),
  .tx_stop_done_i(tx_stop_done_i), .tx_guard_hold_o(tx_guard_hold_o),
  .smartcard_mode_i(smartcard_mode_i), .card_clk_tick_i(card_clk_tick_i),
  .sc_baud_tick_o(sc_baud_tick_o), .oversample16_i(oversample16_i),
  .man_cfg_o(man_cfg_o), .lin_cfg_o(lin_cfg_o));
